// [rtl/sfe_pkg.sv]
package sfe_pkg;

  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned INACT_LSB_MS = 1000;
  localparam int unsigned FALL_LSB_US  = 5000;
  localparam int unsigned INACT_TICK_CYC = CLK_HZ / 1000 * INACT_LSB_MS;
  localparam int unsigned FALL_TICK_CYC  = CLK_HZ / 1_000_000 * FALL_LSB_US;
  localparam int unsigned QUEUE_DEPTH  = 32;

  localparam logic [7:0] ADDR_INACT_THR  = 8'h25;
  localparam logic [7:0] ADDR_INACT_TIME = 8'h26;
  localparam logic [7:0] ADDR_AXIS_SEL   = 8'h27;
  localparam logic [7:0] ADDR_FALL_THR   = 8'h28;
  localparam logic [7:0] ADDR_FALL_TIME  = 8'h29;
  localparam logic [7:0] ADDR_EVENT_SRC  = 8'h30;
  localparam logic [7:0] ADDR_X_LO       = 8'h32;
  localparam logic [7:0] ADDR_Z_HI       = 8'h37;
  localparam logic [7:0] ADDR_QUEUE_CTL  = 8'h38;
  localparam logic [7:0] ADDR_QUEUE_STAT = 8'h39;
  localparam logic [7:0] ADDR_ORIENT_CFG = 8'h3B;
  localparam logic [7:0] REG_RESET       = 8'h00;

  localparam int unsigned QC_MODE_LO  = 6;
  localparam int unsigned QC_TRIG_SEL = 5;
  localparam int unsigned OC_3D_SEL   = 3;
  localparam int unsigned OC_DZ_LO    = 4;
  localparam int unsigned EV_ORIENT   = 4;
  localparam int unsigned EV_INACT    = 3;
  localparam int unsigned EV_FALL     = 2;
  localparam int unsigned EV_WMARK    = 1;
  localparam int unsigned EV_OVERRUN  = 0;

  typedef enum logic [1:0] {
    MODE_BYPASS = 2'h0,
    MODE_FILL   = 2'h1,
    MODE_STREAM = 2'h2,
    MODE_TRIG   = 2'h3
  } sfe_mode_t;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } sfe_sample_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfe_reg_req_t;

  typedef struct packed {
    logic orientation;
    logic inactivity;
    logic free_fall;
    logic watermark;
    logic overrun;
  } sfe_flags_t;

  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : abs16

  // threshold lsb sits at bit 4 of the sample magnitude
  function automatic logic below_thr(input logic signed [15:0] v, input logic [7:0] thr);
    below_thr = abs16(v) < {4'h0, thr, 4'h0};
  endfunction : below_thr
endpackage : sfe_pkg

// [rtl/sfe_sample_queue.sv]
`timescale 1ns/100ps
module sfe_sample_queue
  import sfe_pkg::*;
#(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = $clog2(DEPTH)
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  input  wire logic             push_i,
  input  wire logic             pop_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] rdata_o,
  output logic      [AW:0]      count_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             do_push;
  logic             do_pop;

  assign do_pop  = pop_i && (count_reg != '0);
  assign do_push = push_i && ((count_reg != (AW+1)'(DEPTH)) || do_pop);
  assign rdata_o = mem[rd_ptr_reg];
  assign count_o = count_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (do_push)
    begin
      mem[wr_ptr_reg] <= wdata_i;
    end
  end

  // count follows every push and pop in the same edge
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i || flush_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
      end
      if (do_pop)
      begin
        rd_ptr_reg <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
      end
      count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : sfe_sample_queue

// [rtl/sfe_orient_track.sv]
`timescale 1ns/100ps
module sfe_orient_track
  import sfe_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         sample_valid_i,
  input  wire sfe_sample_t  sample_i,
  input  wire logic         sel_3d_i,
  input  wire logic [2:0]   dead_zone_i,
  output logic              change_o
);
  logic [15:0] ax;
  logic [15:0] ay;
  logic [15:0] az;
  logic [15:0] big;
  logic [15:0] second;
  logic [15:0] margin;
  logic [2:0]  code;
  logic        valid;
  logic [2:0]  last_code_reg;
  logic        have_last_reg;

  assign margin = {3'h0, dead_zone_i, 10'h000};

  always_comb
  begin
    ax = abs16(sample_i.x);
    ay = abs16(sample_i.y);
    az = abs16(sample_i.z);
    if (ax >= ay && (!sel_3d_i || ax >= az))
    begin
      big    = ax;
      second = (sel_3d_i && az > ay) ? az : ay;
      code   = {2'h0, sample_i.x[15]};
    end
    else if (!sel_3d_i || ay >= az)
    begin
      big    = ay;
      second = (sel_3d_i && az > ax) ? az : ax;
      code   = {2'h1, sample_i.y[15]};
    end
    else
    begin
      big    = az;
      second = (ax > ay) ? ax : ay;
      code   = {2'h2, sample_i.z[15]};
    end
    // dominance inside the margin is the dead zone / hysteresis band
    valid = (big - second) > margin;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      last_code_reg <= 3'h0;
      have_last_reg <= 1'b0;
      change_o      <= 1'b0;
    end
    else
    begin
      change_o <= 1'b0;
      if (sample_valid_i && valid)
      begin
        last_code_reg <= code;
        have_last_reg <= 1'b1;
        change_o      <= have_last_reg && (code != last_code_reg);
      end
    end
  end
endmodule : sfe_orient_track

// [rtl/sfe_event_queue.sv]
`timescale 1ns/100ps
module sfe_event_queue
  import sfe_pkg::*;
#(
  parameter int unsigned DEPTH          = QUEUE_DEPTH,
  parameter int unsigned INACT_TICK     = INACT_TICK_CYC,
  parameter int unsigned FALL_TICK      = FALL_TICK_CYC
)
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_b_i,
  input  wire sfe_reg_req_t         reg_req_i,
  output logic [7:0]                reg_rdata_o,
  input  wire logic                 sample_valid_i,
  input  wire sfe_sample_t          sample_i,
  input  wire logic                 event_line_one_i,
  input  wire logic                 event_line_two_i,
  output sfe_flags_t                event_flags_o
);
  import sfe_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);

  logic [7:0]   inactivity_threshold_reg;
  logic [7:0]   inactivity_time_reg;
  logic [7:0]   motion_axis_select_reg;
  logic [7:0]   fall_threshold_reg;
  logic [7:0]   fall_time_reg;
  logic [7:0]   queue_control_reg;
  logic [7:0]   orientation_config_reg;
  sfe_sample_t  out_sample_reg;
  logic         out_unread_reg;
  logic         out_loaded_reg;
  logic         trig_done_reg;
  logic         trimming_reg;
  logic         line_one_reg;
  logic         line_two_reg;
  logic         full_prev_reg;
  logic [31:0]  inact_pre_reg;
  logic [31:0]  fall_pre_reg;
  logic [8:0]   inact_cnt_reg;
  logic [8:0]   fall_cnt_reg;
  logic         inact_quiet_reg;
  logic         fall_quiet_reg;
  sfe_flags_t   flags_reg;

  sfe_mode_t    mode;
  logic [4:0]   samples_n;
  logic         is_write;
  logic         is_read;
  logic         data_read;
  logic         src_read;
  logic         flush;
  logic         push;
  logic         pop;
  logic         prefetch;
  logic         trig_edge;
  logic         full;
  logic         wmark;
  logic [AW:0]  count;
  sfe_sample_t  head;
  logic         orient_change;
  logic         inact_tick;
  logic         fall_tick;
  logic         inact_hit;
  logic         fall_hit;
  logic         bypass_over;
  logic         queue_over;

  assign mode      = sfe_mode_t'(queue_control_reg[QC_MODE_LO +: 2]);
  assign samples_n = queue_control_reg[4:0];
  assign is_write  = reg_req_i.wr;
  assign is_read   = reg_req_i.rd;
  // a read of the last data byte ends a sample burst and pops the queue
  assign data_read = is_read && (reg_req_i.addr == ADDR_Z_HI);
  assign src_read  = is_read && (reg_req_i.addr == ADDR_EVENT_SRC);
  assign flush     = (mode == MODE_BYPASS);
  assign full      = (count == (AW+1)'(DEPTH));
  assign wmark     = (count >= {1'b0, samples_n}) && (mode != MODE_BYPASS);

  // trigger comes from the rising edge of the selected event line
  assign trig_edge = queue_control_reg[QC_TRIG_SEL]
                   ? (event_line_two_i && !line_two_reg)
                   : (event_line_one_i && !line_one_reg);

  always_comb
  begin
    push = 1'b0;
    pop  = 1'b0;
    case (mode)
      MODE_FILL:
      begin
        push = sample_valid_i && !full;
      end
      MODE_STREAM:
      begin
        push = sample_valid_i;
        pop  = sample_valid_i && full;
      end
      MODE_TRIG:
      begin
        if (trig_done_reg)
        begin
          push = sample_valid_i && !full;
        end
        else
        begin
          push = sample_valid_i;
          pop  = sample_valid_i && full;
        end
      end
      default:
      begin
        push = 1'b0;
      end
    endcase
    prefetch = !flush && !out_loaded_reg && (count != '0) && !trimming_reg;
    // drop oldest entries one per cycle until only n remain
    if (trimming_reg && (count > (AW+1)'(samples_n)))
    begin
      pop = 1'b1;
    end
    if (prefetch)
    begin
      pop = 1'b1;
    end
  end

  assign bypass_over = (mode == MODE_BYPASS) && sample_valid_i && out_unread_reg;
  assign queue_over  = (mode != MODE_BYPASS) && full && !full_prev_reg;

  sfe_sample_queue #(
    .WIDTH (48),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_queue (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .flush_i   (flush),
    .push_i    (push),
    .pop_i     (pop),
    .wdata_i   (sample_i),
    .rdata_o   (head),
    .count_o   (count)
  );

  sfe_orient_track u_orient (
    .sys_clk_i      (sys_clk_i),
    .rst_b_i        (rst_b_i),
    .sample_valid_i (sample_valid_i),
    .sample_i       (sample_i),
    .sel_3d_i       (orientation_config_reg[OC_3D_SEL]),
    .dead_zone_i    (orientation_config_reg[OC_DZ_LO +: 3]),
    .change_o       (orient_change)
  );

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      inactivity_threshold_reg <= REG_RESET;
      inactivity_time_reg      <= REG_RESET;
      motion_axis_select_reg   <= REG_RESET;
      fall_threshold_reg       <= REG_RESET;
      fall_time_reg            <= REG_RESET;
      queue_control_reg        <= REG_RESET;
      orientation_config_reg   <= REG_RESET;
    end
    else if (is_write)
    begin
      case (reg_req_i.addr)
        ADDR_INACT_THR:  inactivity_threshold_reg <= reg_req_i.wdata;
        ADDR_INACT_TIME: inactivity_time_reg      <= reg_req_i.wdata;
        ADDR_AXIS_SEL:   motion_axis_select_reg   <= reg_req_i.wdata;
        ADDR_FALL_THR:   fall_threshold_reg       <= reg_req_i.wdata;
        ADDR_FALL_TIME:  fall_time_reg            <= reg_req_i.wdata;
        ADDR_QUEUE_CTL:  queue_control_reg        <= reg_req_i.wdata;
        ADDR_ORIENT_CFG: orientation_config_reg   <= reg_req_i.wdata;
        default:         inactivity_threshold_reg <= inactivity_threshold_reg;
      endcase
    end
  end

  // axis output registers: live samples in bypass, queue head otherwise
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      out_sample_reg <= '0;
      out_unread_reg <= 1'b0;
      out_loaded_reg <= 1'b0;
    end
    else if (mode == MODE_BYPASS)
    begin
      out_loaded_reg <= 1'b0;
      if (sample_valid_i)
      begin
        out_sample_reg <= sample_i;
        out_unread_reg <= 1'b1;
      end
      else if (data_read)
      begin
        out_unread_reg <= 1'b0;
      end
    end
    else
    begin
      out_unread_reg <= 1'b0;
      if (prefetch)
      begin
        out_sample_reg <= head;
        out_loaded_reg <= 1'b1;
      end
      else if (data_read)
      begin
        out_loaded_reg <= 1'b0;
      end
    end
  end

  // trigger capture, single shot until bypass re-arms it
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      line_one_reg  <= 1'b0;
      line_two_reg  <= 1'b0;
      trig_done_reg <= 1'b0;
      trimming_reg  <= 1'b0;
      full_prev_reg <= 1'b0;
    end
    else
    begin
      line_one_reg  <= event_line_one_i;
      line_two_reg  <= event_line_two_i;
      full_prev_reg <= full;
      if (mode == MODE_BYPASS)
      begin
        trig_done_reg <= 1'b0;
        trimming_reg  <= 1'b0;
      end
      else if (mode == MODE_TRIG && trig_edge && !trig_done_reg)
      begin
        trig_done_reg <= 1'b1;
        trimming_reg  <= 1'b1;
      end
      else if (trimming_reg && (count <= (AW+1)'(samples_n) + (AW+1)'(pop)))
      begin
        trimming_reg <= 1'b0;
      end
    end
  end

  // inactivity and free-fall timers in ticks of 1 s and 5 ms
  assign inact_tick = (inact_pre_reg == 32'(INACT_TICK - 1));
  assign fall_tick  = (fall_pre_reg == 32'(FALL_TICK - 1));
  assign inact_hit  = inact_quiet_reg && (inact_cnt_reg > {1'b0, inactivity_time_reg});
  assign fall_hit   = fall_quiet_reg && (fall_cnt_reg > {1'b0, fall_time_reg});

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      inact_pre_reg   <= '0;
      fall_pre_reg    <= '0;
      inact_quiet_reg <= 1'b0;
      fall_quiet_reg  <= 1'b0;
    end
    else
    begin
      inact_pre_reg <= inact_tick ? '0 : inact_pre_reg + 32'h0000_0001;
      fall_pre_reg  <= fall_tick ? '0 : fall_pre_reg + 32'h0000_0001;
      if (sample_valid_i)
      begin
        inact_quiet_reg <= (motion_axis_select_reg[2:0] != 3'h0)
          && (!motion_axis_select_reg[2] || below_thr(sample_i.x, inactivity_threshold_reg))
          && (!motion_axis_select_reg[1] || below_thr(sample_i.y, inactivity_threshold_reg))
          && (!motion_axis_select_reg[0] || below_thr(sample_i.z, inactivity_threshold_reg));
        fall_quiet_reg <= below_thr(sample_i.x, fall_threshold_reg)
          && below_thr(sample_i.y, fall_threshold_reg)
          && below_thr(sample_i.z, fall_threshold_reg);
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      inact_cnt_reg <= '0;
      fall_cnt_reg  <= '0;
    end
    else
    begin
      if (!inact_quiet_reg)
      begin
        inact_cnt_reg <= '0;
      end
      else if (inact_tick && inact_cnt_reg != 9'h1FF)
      begin
        inact_cnt_reg <= inact_cnt_reg + 9'h001;
      end
      if (!fall_quiet_reg)
      begin
        fall_cnt_reg <= '0;
      end
      else if (fall_tick && fall_cnt_reg != 9'h1FF)
      begin
        fall_cnt_reg <= fall_cnt_reg + 9'h001;
      end
    end
  end

  // latched flags, watermark excepted as it follows wmark; a set in the clearing cycle wins
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      flags_reg <= '0;
    end
    else
    begin
      flags_reg.watermark   <= wmark;
      flags_reg.overrun     <= (bypass_over || queue_over)
                             || (flags_reg.overrun && !data_read);
      flags_reg.orientation <= orient_change || (flags_reg.orientation && !src_read);
      flags_reg.inactivity  <= inact_hit || (flags_reg.inactivity && !src_read);
      flags_reg.free_fall   <= fall_hit || (flags_reg.free_fall && !src_read);
    end
  end

  assign event_flags_o = flags_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (is_read)
    begin
      case (reg_req_i.addr)
        ADDR_INACT_THR:  reg_rdata_o <= inactivity_threshold_reg;
        ADDR_INACT_TIME: reg_rdata_o <= inactivity_time_reg;
        ADDR_AXIS_SEL:   reg_rdata_o <= motion_axis_select_reg;
        ADDR_FALL_THR:   reg_rdata_o <= fall_threshold_reg;
        ADDR_FALL_TIME:  reg_rdata_o <= fall_time_reg;
        ADDR_QUEUE_CTL:  reg_rdata_o <= queue_control_reg;
        ADDR_ORIENT_CFG: reg_rdata_o <= orientation_config_reg;
        ADDR_EVENT_SRC:  reg_rdata_o <= {3'h0, flags_reg};
        ADDR_QUEUE_STAT: reg_rdata_o <= {trig_done_reg, 1'b0, 6'(count)};
        8'h32:           reg_rdata_o <= out_sample_reg.x[7:0];
        8'h33:           reg_rdata_o <= out_sample_reg.x[15:8];
        8'h34:           reg_rdata_o <= out_sample_reg.y[7:0];
        8'h35:           reg_rdata_o <= out_sample_reg.y[15:8];
        8'h36:           reg_rdata_o <= out_sample_reg.z[7:0];
        ADDR_Z_HI:       reg_rdata_o <= out_sample_reg.z[15:8];
        default:         reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule : sfe_event_queue

// [tb/sfe_event_queue_asserts.sv]
`timescale 1ns/100ps
module sfe_event_queue_asserts
  import sfe_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire sfe_reg_req_t reg_req_i,
  input  wire logic [7:0]   reg_rdata_o,
  input  wire logic         sample_valid_i,
  input  wire sfe_sample_t  sample_i,
  input  wire sfe_flags_t   event_flags_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [1:0] mode_reg;
  logic [7:0] fthr_reg;
  logic [7:0] ithr_reg;
  logic [2:0] axis_reg;
  logic [2:0] since_pop_reg;
  logic       flow_reg;
  logic       ilow_reg;
  logic       wr_qc;
  logic       rd_pop;
  assign wr_qc  = reg_req_i.wr && reg_req_i.addr == ADDR_QUEUE_CTL;
  assign rd_pop = reg_req_i.rd && reg_req_i.addr == ADDR_Z_HI;
  function automatic logic low(input logic signed [15:0] v, input logic [7:0] t);
    low = (v[15] ? 16'(-v) : 16'(v)) < {4'h0, t, 4'h0};
  endfunction : low
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      mode_reg <= 2'h0;
      fthr_reg <= 8'h00;
      ithr_reg <= 8'h00;
      axis_reg <= 3'h0;
    end
    else if (reg_req_i.wr)
    begin
      if (wr_qc) mode_reg <= reg_req_i.wdata[7:6];
      if (reg_req_i.addr == ADDR_FALL_THR) fthr_reg <= reg_req_i.wdata;
      if (reg_req_i.addr == ADDR_INACT_THR) ithr_reg <= reg_req_i.wdata;
      if (reg_req_i.addr == ADDR_AXIS_SEL) axis_reg <= reg_req_i.wdata[2:0];
    end
  end
  // last sample's below-threshold state per detector
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      flow_reg <= 1'b0;
      ilow_reg <= 1'b0;
    end
    else if (sample_valid_i)
    begin
      flow_reg <= low(sample_i.x, fthr_reg) && low(sample_i.y, fthr_reg)
                  && low(sample_i.z, fthr_reg);
      ilow_reg <= (axis_reg != 3'h0) && (!axis_reg[2] || low(sample_i.x, ithr_reg))
                  && (!axis_reg[1] || low(sample_i.y, ithr_reg))
                  && (!axis_reg[0] || low(sample_i.z, ithr_reg));
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i) since_pop_reg <= 3'h7;
    else if (rd_pop || wr_qc) since_pop_reg <= 3'h0;
    else if (since_pop_reg != 3'h7) since_pop_reg <= since_pop_reg + 3'h1;
  end
  property p_ovr_clear;
    rd_pop && !sample_valid_i && !$past(sample_valid_i) |=> !event_flags_o.overrun;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun kept after data read");
  property p_orient_clear;
    reg_req_i.rd && reg_req_i.addr == ADDR_EVENT_SRC && !sample_valid_i
      && !$past(sample_valid_i) |=> !event_flags_o.orientation;
  endproperty
  a_orient_clear: assert property (p_orient_clear) else $error("orient kept");
  property p_bypass_empty;
    mode_reg == MODE_BYPASS && $past(mode_reg) == MODE_BYPASS
      && $past(mode_reg, 2) == MODE_BYPASS |-> !event_flags_o.watermark;
  endproperty
  a_bypass_empty: assert property (p_bypass_empty) else $error("watermark in bypass");
  property p_ovr_cause;
    $rose(event_flags_o.overrun) |-> $past(sample_valid_i) || $past(sample_valid_i, 2);
  endproperty
  a_ovr_cause: assert property (p_ovr_cause) else $error("overrun with no sample");
  property p_fill_hold;
    mode_reg == MODE_FILL && event_flags_o.watermark && since_pop_reg > 3'h2 && !rd_pop
      && !wr_qc |=> event_flags_o.watermark;
  endproperty
  a_fill_hold: assert property (p_fill_hold) else $error("watermark dropped");
  property p_wm_fall;
    $fell(event_flags_o.watermark) |-> since_pop_reg < 3'h4;
  endproperty
  a_wm_fall: assert property (p_wm_fall) else $error("watermark fell with no read");
  property p_fall_cause;
    $rose(event_flags_o.free_fall) |-> flow_reg || $past(flow_reg);
  endproperty
  a_fall_cause: assert property (p_fall_cause) else $error("free fall not low");
  property p_inact_cause;
    $rose(event_flags_o.inactivity) |-> ilow_reg || $past(ilow_reg);
  endproperty
  a_inact_cause: assert property (p_inact_cause) else $error("inactivity not low");
  c_ovr: cover property ($rose(event_flags_o.overrun));
  c_fall: cover property ($rose(event_flags_o.free_fall));
  c_orient: cover property ($rose(event_flags_o.orientation));
endmodule : sfe_event_queue_asserts

// [tb/sfe_host_model.sv]
`timescale 1ns/100ps
module sfe_host_model
  import sfe_pkg::*;
(
  input  wire logic    sys_clk_i,
  output sfe_reg_req_t reg_req_o
);
  initial reg_req_o = '0;
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_req_o <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge sys_clk_i);
    reg_req_o <= '0;
  endtask : access
  // bypass first, which also flushes the queue, then write the given ctl value
  task automatic rearm(input logic [7:0] ctl);
    access(1'b1, ADDR_QUEUE_CTL, 8'h00);
    access(1'b1, ADDR_QUEUE_CTL, ctl);
  endtask : rearm
  // 5.2 us at 25 MHz before reading after a trigger
  task automatic settle();
    repeat (130) @(negedge sys_clk_i);
  endtask : settle
endmodule : sfe_host_model

// [tb/sfe_event_queue_tb.sv]
`timescale 1ns/100ps
module sfe_event_queue_tb;
  import sfe_pkg::*;
  localparam logic [7:0] CFG_A [7] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h38, 8'h3B};
  logic         sys_clk = 1'b0;
  logic         rst_b;
  sfe_reg_req_t req;
  logic [7:0]   rdata;
  logic         smp_vld;
  sfe_sample_t  smp;
  logic         line_one;
  logic         line_two;
  sfe_flags_t   flags;
  int           n_errors;
  int           check_count;
  int           seed;
  logic [7:0]   d;
  logic [15:0]  d16;
  logic [15:0]  note;
  logic [15:0]  exp_q[$];
  always #20 sys_clk = ~sys_clk;
  sfe_event_queue #(.INACT_TICK(10), .FALL_TICK(4)) dut_u (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .reg_req_i(req), .reg_rdata_o(rdata),
    .sample_valid_i(smp_vld), .sample_i(smp), .event_line_one_i(line_one),
    .event_line_two_i(line_two), .event_flags_o(flags));
  sfe_host_model host_u (.sys_clk_i(sys_clk), .reg_req_o(req));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_u.access(1'b1, a, v);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    exp_q.push_back({m, x});
    host_u.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle
  task automatic push(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(negedge sys_clk);
    smp <= '{x: x, y: y, z: z};
    smp_vld <= 1'b1;
    @(negedge sys_clk);
    smp_vld <= 1'b0;
  endtask : push
  task automatic fill_up(input int n);
    for (int i = 1; i <= n; i++)
      push(16'(i), 16'h0000, {8'(i), 8'h00});
  endtask : fill_up
  task automatic pulse(input logic two);
    @(negedge sys_clk);
    if (two) line_two <= 1'b1;
    else line_one <= 1'b1;
    idle(2);
    line_one <= 1'b0;
    line_two <= 1'b0;
  endtask : pulse
  // read data is settled at the falling edge after the taking edge
  always @(posedge sys_clk)
  begin
    if (rst_b === 1'b1 && req.rd === 1'b1)
    begin
      @(negedge sys_clk);
      note = exp_q.pop_front();
      chk("read data", rdata & note[15:8], note[7:0] & note[15:8]);
    end
  end
  initial
  begin
    seed = 32'h7576ACC9;
    rst_b = 1'b0;
    smp_vld = 1'b0;
    smp = '0;
    line_one = 1'b0;
    line_two = 1'b0;
    n_errors = 0;
    check_count = 0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    foreach (CFG_A[i])
    begin
      d = 8'($random(seed));
      rd(CFG_A[i], REG_RESET, 8'hFF);
      wr(CFG_A[i], d);
      rd(CFG_A[i], d, 8'hFF);
      wr(CFG_A[i], 8'h00);
    end
    wr(8'h10, 8'hA5);
    rd(8'h10, 8'h00, 8'hFF);
    $display("test registers done");
    d16 = 16'($random(seed));
    push(16'h0001, 16'h0002, 16'h0003);
    push(16'h0011, 16'h0022, d16);
    idle(2);
    chk("overrun", 8'(flags.overrun), 8'h01);
    rd(ADDR_QUEUE_STAT, 8'h00, 8'hFF);
    rd(ADDR_Z_HI, d16[15:8], 8'hFF);
    idle(2);
    chk("overrun", 8'(flags.overrun), 8'h00);
    $display("test bypass done");
    wr(ADDR_QUEUE_CTL, 8'h44);
    fill_up(40);
    idle(3);
    rd(ADDR_QUEUE_STAT, 8'h20, 8'hFF);
    chk("overrun", 8'(flags.overrun), 8'h01);
    chk("watermark", 8'(flags.watermark), 8'h01);
    for (int k = 1; k <= 29; k++)
    begin
      rd(ADDR_X_LO, 8'(k), 8'hFF);
      rd(ADDR_Z_HI, 8'(k), 8'hFF);
      idle(2);
      if (k == 1) chk("overrun", 8'(flags.overrun), 8'h00);
      if (k == 28) chk("watermark", 8'(flags.watermark), 8'h01);
    end
    chk("watermark", 8'(flags.watermark), 8'h00);
    rd(ADDR_QUEUE_STAT, 8'h03, 8'hFF);
    $display("test fill done");
    host_u.rearm(8'h84);
    fill_up(40);
    idle(3);
    rd(ADDR_QUEUE_STAT, 8'h20, 8'hFF);
    chk("overrun", 8'(flags.overrun), 8'h01);
    wr(ADDR_QUEUE_CTL, 8'h00);
    rd(ADDR_QUEUE_STAT, 8'h00, 8'hFF);
    $display("test stream done");
    wr(ADDR_QUEUE_CTL, 8'hE4);
    fill_up(10);
    pulse(1'b0);
    idle(40);
    rd(ADDR_QUEUE_STAT, 8'h09, 8'hFF);
    pulse(1'b1);
    host_u.settle();
    rd(ADDR_QUEUE_STAT, 8'h84, 8'hFF);
    fill_up(2);
    pulse(1'b1);
    host_u.settle();
    rd(ADDR_QUEUE_STAT, 8'h86, 8'hFF);
    host_u.rearm(8'hE4);
    rd(ADDR_QUEUE_STAT, 8'h00, 8'hFF);
    host_u.rearm(8'hC4);
    pulse(1'b0);
    rd(ADDR_QUEUE_STAT, 8'h80, 8'hFF);
    $display("test trigger done");
    wr(ADDR_QUEUE_CTL, 8'h00);
    foreach (CFG_A[i])
      if (i < 5) wr(CFG_A[i], i == 2 ? 8'h04 : i == 1 ? 8'h01 : i == 4 ? 8'h02 : 8'h10);
    push(16'd1, 16'd4000, 16'd4000);
    idle(60);
    chk("inactivity", 8'(flags.inactivity), 8'h01);
    chk("free fall", 8'(flags.free_fall), 8'h00);
    rd(ADDR_EVENT_SRC, 8'h08, 8'h0C);
    push(16'd1, 16'd1, 16'd1);
    idle(40);
    rd(ADDR_EVENT_SRC, 8'h04, 8'h04);
    $display("test motion done");
    wr(ADDR_ORIENT_CFG, 8'h10);
    push(16'd16000, 16'd0, 16'd0);
    idle(4);
    rd(ADDR_EVENT_SRC, 8'h10, 8'h10);
    push(16'd8000, 16'd8000, 16'd0);
    push(16'd16000, 16'd0, 16'd0);
    idle(4);
    chk("orientation", 8'(flags.orientation), 8'h00);
    push(16'd0, 16'd16000, 16'd0);
    idle(4);
    rd(ADDR_EVENT_SRC, 8'h10, 8'h10);
    idle(2);
    chk("orientation", 8'(flags.orientation), 8'h00);
    // z dominant is only a valid orientation with the 3D set selected
    wr(ADDR_ORIENT_CFG, 8'h18);
    push(16'd0, 16'd0, 16'd16000);
    idle(4);
    rd(ADDR_EVENT_SRC, 8'h10, 8'h10);
    $display("test orientation done");
    idle(4);
    report_and_stop();
  end
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end
endmodule : sfe_event_queue_tb
bind sfe_event_queue sfe_event_queue_asserts chk_u (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .sample_valid_i(sample_valid_i), .sample_i(sample_i), .event_flags_o(event_flags_o));
